// ==== core/exposure_ctrl_pkg.sv ====
// Package: constants shared by the line scan exposure controller files
// Summary of operation
// - Off mode: free-running, no duration control
// - Timed mode: trigger starts preset-length exposure
// - Pulse mode: exposure follows trigger active width
// - Timed and pulse exposures get sensor offset
// - Offset 3.11us colour, 1.54us monochrome
// - Duration minimum 0.11us, step 0.01us
// - Common sharing: one duration for RGB
// - Individual sharing: per-channel durations, picked channel
// - Individual: channel exposures staggered, end together
// - Non-timed mode forces common sharing
// - Duration priority refuses line period below exposure
// - Rate priority clamps duration to line period
// - TTL pulse minima and width corrections applied
// - Internal trigger delays 2.00/0.13/0.91us
// - TTL delays 2.13/2.41us off, 0.50us pulse-low
// - Exposure indication includes the sensor offset
package exposure_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clock and time units
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 100;            // 10 MHz mclk
  localparam int UNIT_NS         = 10;             // 0.01 us setting step
  localparam int UNITS_PER_CLK   = CLK_PERIOD_NS / UNIT_NS;
  localparam int UNIT_W          = 24;             // Width of unit counters

  // Duration limits and reset values, in 0.01 us units
  localparam logic [23:0] DUR_MIN_UNITS     = 24'h00000b; // 0.11 us
  localparam logic [23:0] DUR_RESET_UNITS   = 24'h0003e8; // 10 us
  localparam logic [23:0] PERIOD_RESET_UNITS = 24'h002710; // 100 us

  // Sensor offset per variant, and TTL width corrections, in ns
  localparam int OFFSET_COLOUR_NS = 3110;
  localparam int OFFSET_MONO_NS   = 1540;
  localparam int CORR_TTL_HI_NS   = 420;
  localparam int CORR_TTL_LO_NS   = 60;
  localparam int OFFSET_COLOUR_UNITS = OFFSET_COLOUR_NS / UNIT_NS;
  localparam int OFFSET_MONO_UNITS   = OFFSET_MONO_NS / UNIT_NS;
  localparam int CORR_TTL_HI_UNITS   = CORR_TTL_HI_NS / UNIT_NS;
  localparam int CORR_TTL_LO_UNITS   = CORR_TTL_LO_NS / UNIT_NS;

  // Trigger to exposure delays, ns, by source then mode
  localparam int DLY_INT_OFF_NS   = 2000;
  localparam int DLY_INT_TIM_NS   = 130;
  localparam int DLY_INT_PW_NS    = 910;
  localparam int DLY_TTLH_OFF_NS  = 2130;
  localparam int DLY_TTLH_TIM_NS  = 250;
  localparam int DLY_TTLH_PW_NS   = 210;
  localparam int DLY_TTLL_OFF_NS  = 2410;
  localparam int DLY_TTLL_TIM_NS  = 540;
  localparam int DLY_TTLL_PW_NS   = 500;
  localparam int DLY_OPTO_OFF_NS  = 2000;
  localparam int DLY_OPTO_TIM_NS  = 200;
  localparam int DLY_OPTO_PW_NS   = 160;

  // Least delays round up to whole cycles
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ----------------------------------------------------------------
  // Register map (byte offsets on the plain port)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_DURATION = 4'h4;
  localparam logic [3:0] REG_PERIOD   = 4'h8;
  localparam logic [3:0] REG_STATUS   = 4'hc;

  // Control field positions
  localparam int CTRL_MODE_LSB  = 0;  // 2 bits
  localparam int CTRL_SHARE_BIT = 2;
  localparam int CTRL_PICK_LSB  = 3;  // 2 bits
  localparam int CTRL_PRIO_BIT  = 5;
  localparam int CTRL_TRIG_BIT  = 6;
  localparam int CTRL_SRC_LSB   = 7;  // 3 bits
  localparam logic [9:0] CTRL_RESET = 10'h000;

  // Exposure control select encoding
  typedef enum logic [1:0] {
    MODE_OFF   = 2'h0,
    MODE_TIMED = 2'h1,
    MODE_PULSE = 2'h2
  } exp_mode_t;

  // Trigger source encoding
  typedef enum logic [2:0] {
    SRC_INTERNAL = 3'h0,
    SRC_TTL_HI   = 3'h1,
    SRC_TTL_LO   = 3'h2,
    SRC_OPTO_HI  = 3'h3,
    SRC_OPTO_LO  = 3'h4
  } trig_src_t;

  // Sequencer states, Gray along idle-delay-expose-offset
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DELAY  = 2'b01,
    ST_EXPOSE = 2'b11,
    ST_OFFSET = 2'b10
  } exp_state_t;

endpackage

// ==== core/unit_down_counter.sv ====
// Saturating down counter with load, used for delays and exposure spans
`timescale 1ns/100ps
module unit_down_counter #(
  parameter int W    = 24,
  parameter int STEP = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         load,      // Load takes priority over counting
  input  wire logic [W-1:0] loadValue,
  output logic      [W-1:0] count,
  output logic              done       // Last step of the span
);

  localparam logic [W-1:0] STEP_W = W'(STEP);

  // ----------------------------------------------------------------
  // Count down by STEP, stopping at zero
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (load) begin
      count <= loadValue;
    end else if (count > STEP_W) begin
      count <= count - STEP_W;
    end else begin
      count <= '0;
    end
  end

  // Done in the cycle the remainder fits in one step
  assign done = (count <= STEP_W);

endmodule

// ==== core/line_scan_exposure_control.sv ====
// Exposure sequencer, channel staggering and register port of the line scan controller
`timescale 1ns/100ps
module line_scan_exposure_control #(
  parameter bit COLOUR = 1'b1   // 1: trilinear colour, 0: monochrome
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wrData,
  input  wire logic        wrEn,
  input  wire logic        rdEn,
  output logic      [31:0] rdData,
  input  wire logic        trigInternal,      // Same-clock trigger from internal logic
  input  wire logic        trigPin,           // TTL or opto trigger pin
  output logic             exposureInProgress,
  output logic      [2:0]  channelExposure    // Red, green, blue sensor exposure
);

  localparam int W = exposure_ctrl_pkg::UNIT_W;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [9:0]   ctrl;                 // Control word
  logic [W-1:0] dur [3];              // Durations per channel, 0.01 us units
  logic [W-1:0] linePeriod;           // Line period, 0.01 us units
  logic         refused;              // Last period write was refused
  exposure_ctrl_pkg::exp_state_t state;
  exposure_ctrl_pkg::exp_state_t next_state;
  logic         trigMeta;             // Synchroniser first stage
  logic         trigSync;             // Synchroniser second stage
  logic         trigPrev;             // Previous active trigger level

  // Decoded control fields
  exposure_ctrl_pkg::exp_mode_t  mode;
  exposure_ctrl_pkg::trig_src_t  src;
  logic [1:0]   pick;
  logic         rateWins;
  logic         trigEnable;
  logic         individual;           // Effective per-channel sharing

  assign mode       = exposure_ctrl_pkg::exp_mode_t'(ctrl[exposure_ctrl_pkg::CTRL_MODE_LSB +: 2]);
  assign src        = exposure_ctrl_pkg::trig_src_t'(ctrl[exposure_ctrl_pkg::CTRL_SRC_LSB +: 3]);
  assign pick       = ctrl[exposure_ctrl_pkg::CTRL_PICK_LSB +: 2];
  assign rateWins   = ctrl[exposure_ctrl_pkg::CTRL_PRIO_BIT];
  assign trigEnable = ctrl[exposure_ctrl_pkg::CTRL_TRIG_BIT];
  // Colour only, and only while timed
  assign individual = COLOUR && ctrl[exposure_ctrl_pkg::CTRL_SHARE_BIT]
                      && (mode == exposure_ctrl_pkg::MODE_TIMED);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Trigger to exposure delay in cycles for a source and mode
  function automatic logic [W-1:0] delayCycles(input exposure_ctrl_pkg::trig_src_t s,
                                               input exposure_ctrl_pkg::exp_mode_t m);
    int ns;
    ns = exposure_ctrl_pkg::DLY_INT_OFF_NS;
    case (s)
      exposure_ctrl_pkg::SRC_TTL_HI: begin
        ns = (m == exposure_ctrl_pkg::MODE_OFF)   ? exposure_ctrl_pkg::DLY_TTLH_OFF_NS :
             (m == exposure_ctrl_pkg::MODE_TIMED) ? exposure_ctrl_pkg::DLY_TTLH_TIM_NS :
                                                    exposure_ctrl_pkg::DLY_TTLH_PW_NS;
      end
      exposure_ctrl_pkg::SRC_TTL_LO: begin
        ns = (m == exposure_ctrl_pkg::MODE_OFF)   ? exposure_ctrl_pkg::DLY_TTLL_OFF_NS :
             (m == exposure_ctrl_pkg::MODE_TIMED) ? exposure_ctrl_pkg::DLY_TTLL_TIM_NS :
                                                    exposure_ctrl_pkg::DLY_TTLL_PW_NS;
      end
      exposure_ctrl_pkg::SRC_OPTO_HI, exposure_ctrl_pkg::SRC_OPTO_LO: begin
        ns = (m == exposure_ctrl_pkg::MODE_OFF)   ? exposure_ctrl_pkg::DLY_OPTO_OFF_NS :
             (m == exposure_ctrl_pkg::MODE_TIMED) ? exposure_ctrl_pkg::DLY_OPTO_TIM_NS :
                                                    exposure_ctrl_pkg::DLY_OPTO_PW_NS;
      end
      default: begin
        ns = (m == exposure_ctrl_pkg::MODE_OFF)   ? exposure_ctrl_pkg::DLY_INT_OFF_NS :
             (m == exposure_ctrl_pkg::MODE_TIMED) ? exposure_ctrl_pkg::DLY_INT_TIM_NS :
                                                    exposure_ctrl_pkg::DLY_INT_PW_NS;
      end
    endcase
    return W'(exposure_ctrl_pkg::ns2cyc(ns));
  endfunction

  // Raise a written duration to the least legal value
  function automatic logic [W-1:0] atLeastMin(input logic [W-1:0] v);
    return (v < exposure_ctrl_pkg::DUR_MIN_UNITS) ? exposure_ctrl_pkg::DUR_MIN_UNITS : v;
  endfunction

  // ----------------------------------------------------------------
  // Trigger input: pin synchronised, polarity and source chosen
  // ----------------------------------------------------------------
  // Pin passes two flops before any logic looks at it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trigMeta <= 1'b0;
      trigSync <= 1'b0;
    end else begin
      trigMeta <= trigPin;
      trigSync <= trigMeta;
    end
  end

  logic trigActive;
  logic trigEdge;
  // Active-low sources are inverted so active means asserted
  assign trigActive = (src == exposure_ctrl_pkg::SRC_INTERNAL) ? trigInternal :
                      (src == exposure_ctrl_pkg::SRC_TTL_LO ||
                       src == exposure_ctrl_pkg::SRC_OPTO_LO) ? ~trigSync : trigSync;
  assign trigEdge = trigActive & ~trigPrev;

  // Previous level for edge detection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trigPrev <= 1'b0;
    end else begin
      trigPrev <= trigActive;
    end
  end

  // ----------------------------------------------------------------
  // Derived exposure figures
  // ----------------------------------------------------------------
  logic [W-1:0] longest;       // Longest channel duration
  logic [W-1:0] offsetUnits;   // Sensor offset for this variant
  logic [W-1:0] corrUnits;     // Pulse width correction for the source
  logic [W-1:0] offDuration;   // Free-running span in off mode

  always_comb begin
    longest = dur[0];
    if (individual && dur[1] > longest) begin
      longest = dur[1];
    end
    if (individual && dur[2] > longest) begin
      longest = dur[2];
    end
  end

  assign offsetUnits = COLOUR ? W'(exposure_ctrl_pkg::OFFSET_COLOUR_UNITS)
                              : W'(exposure_ctrl_pkg::OFFSET_MONO_UNITS);
  // Internal logic pulses need no correction
  assign corrUnits = (src == exposure_ctrl_pkg::SRC_TTL_HI) ?
                     W'(exposure_ctrl_pkg::CORR_TTL_HI_UNITS) :
                     (src == exposure_ctrl_pkg::SRC_TTL_LO) ?
                     W'(exposure_ctrl_pkg::CORR_TTL_LO_UNITS) :
                     '0;
  // Leave one clock of gap so the next line is never missed
  assign offDuration = (linePeriod > W'(2 * exposure_ctrl_pkg::UNITS_PER_CLK)) ?
                       linePeriod - W'(exposure_ctrl_pkg::UNITS_PER_CLK) :
                       W'(exposure_ctrl_pkg::UNITS_PER_CLK);

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  logic         dLoad, eLoad, lineDone, periodWrite;
  logic [W-1:0] dVal, eVal, eCount;
  logic         dDone, eDone;

  // Delay counter in clock cycles
  unit_down_counter #(.W(W), .STEP(1)) delayCnt (
    .mclk(mclk), .rst_n(rst_n), .load(dLoad), .loadValue(dVal), .count(), .done(dDone));

  // Exposure counter in 0.01 us units, ten per clock
  unit_down_counter #(.W(W), .STEP(exposure_ctrl_pkg::UNITS_PER_CLK)) exposeCnt (
    .mclk(mclk), .rst_n(rst_n), .load(eLoad), .loadValue(eVal), .count(eCount),
    .done(eDone));

  // Line pacing timer for free-running operation
  unit_down_counter #(.W(W), .STEP(exposure_ctrl_pkg::UNITS_PER_CLK)) lineCnt (
    .mclk(mclk), .rst_n(rst_n), .load(lineDone | periodWrite), .loadValue(linePeriod),
    .count(), .done(lineDone));

  // ----------------------------------------------------------------
  // Exposure sequencer
  // ----------------------------------------------------------------
  logic startEvt;
  // Triggers pace lines when enabled, else the line timer
  assign startEvt = trigEnable ? trigEdge : lineDone;

  always_comb begin
    next_state = state;
    dLoad = 1'b0;
    dVal  = delayCycles(src, mode);
    eLoad = 1'b0;
    eVal  = (mode == exposure_ctrl_pkg::MODE_OFF) ? offDuration : longest;
    case (state)
      exposure_ctrl_pkg::ST_IDLE: begin
        // Starts arriving while busy are dropped
        if (startEvt && trigEnable) begin
          next_state = exposure_ctrl_pkg::ST_DELAY;
          dLoad = 1'b1;
        end else if (startEvt) begin
          next_state = exposure_ctrl_pkg::ST_EXPOSE;
          eLoad = 1'b1;
        end
      end
      exposure_ctrl_pkg::ST_DELAY: begin
        if (dDone) begin
          next_state = exposure_ctrl_pkg::ST_EXPOSE;
          eLoad = 1'b1;
        end
      end
      exposure_ctrl_pkg::ST_EXPOSE: begin
        if (mode == exposure_ctrl_pkg::MODE_PULSE && trigEnable) begin
          // Span follows the trigger; correction trims the offset tail
          if (!trigActive) begin
            next_state = exposure_ctrl_pkg::ST_OFFSET;
            eLoad = 1'b1;
            eVal  = offsetUnits - corrUnits;
          end
        end else if (eDone) begin
          // Off mode has no offset tail
          next_state = (mode == exposure_ctrl_pkg::MODE_OFF) ? exposure_ctrl_pkg::ST_IDLE
                                                             : exposure_ctrl_pkg::ST_OFFSET;
          eLoad = (mode != exposure_ctrl_pkg::MODE_OFF);
          eVal  = offsetUnits;
        end
      end
      default: begin
        if (eDone) begin
          next_state = exposure_ctrl_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= exposure_ctrl_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Indication covers exposure and offset tail alike
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      exposureInProgress <= 1'b0;
    end else begin
      exposureInProgress <= (state == exposure_ctrl_pkg::ST_EXPOSE) ||
                            (state == exposure_ctrl_pkg::ST_OFFSET);
    end
  end

  // Channels join once the remaining span fits their own duration
  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_chan
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          channelExposure[c] <= 1'b0;
        end else if (state == exposure_ctrl_pkg::ST_EXPOSE) begin
          channelExposure[c] <= !individual || (eCount <= dur[c]);
        end else begin
          channelExposure[c] <= (state == exposure_ctrl_pkg::ST_OFFSET);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  logic [W-1:0] wrDur;
  logic         durWrite;
  assign durWrite    = wrEn && (addr == exposure_ctrl_pkg::REG_DURATION);
  assign periodWrite = wrEn && (addr == exposure_ctrl_pkg::REG_PERIOD);
  // Under rate priority a duration cannot pass the line period
  assign wrDur = (rateWins && atLeastMin(wrData[W-1:0]) > linePeriod) ?
                 linePeriod : atLeastMin(wrData[W-1:0]);

  // Control word; sharing drops to common outside timed mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= exposure_ctrl_pkg::CTRL_RESET;
    end else if (wrEn && addr == exposure_ctrl_pkg::REG_CTRL) begin
      ctrl <= wrData[9:0];
      if (wrData[1:0] != exposure_ctrl_pkg::MODE_TIMED) begin
        ctrl[exposure_ctrl_pkg::CTRL_SHARE_BIT] <= 1'b0;
      end
    end
  end

  // Durations: common writes all, individual writes the picked one
  generate
    for (c = 0; c < 3; c++) begin : g_dur
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          dur[c] <= exposure_ctrl_pkg::DUR_RESET_UNITS;
        end else if (durWrite && (!individual || pick == 2'(c))) begin
          dur[c] <= wrDur;
        end else if (periodWrite && rateWins && dur[c] > wrData[W-1:0]) begin
          dur[c] <= atLeastMin(wrData[W-1:0]);
        end
      end
    end
  endgenerate

  // Line period; duration priority refuses periods below the exposure
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      linePeriod <= exposure_ctrl_pkg::PERIOD_RESET_UNITS;
      refused    <= 1'b0;
    end else if (periodWrite) begin
      refused <= !rateWins && (wrData[W-1:0] < longest);
      if (rateWins || wrData[W-1:0] >= longest) begin
        linePeriod <= atLeastMin(wrData[W-1:0]);
      end
    end else if (durWrite && !rateWins && wrDur > linePeriod) begin
      // A longer exposure slows the line to fit it
      linePeriod <= wrDur;
    end
  end

  // ----------------------------------------------------------------
  // Register reads, data valid the cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= '0;
    end else if (!rdEn) begin
      rdData <= '0;
    end else if (addr == exposure_ctrl_pkg::REG_CTRL) begin
      rdData <= {22'h0, ctrl};
    end else if (addr == exposure_ctrl_pkg::REG_DURATION) begin
      rdData <= {8'h00, individual ? dur[pick] : dur[0]};
    end else if (addr == exposure_ctrl_pkg::REG_PERIOD) begin
      rdData <= {8'h00, linePeriod};
    end else if (addr == exposure_ctrl_pkg::REG_STATUS) begin
      rdData <= {27'h0, refused, individual, state, exposureInProgress};
    end else begin
      rdData <= '0;
    end
  end

endmodule

// ==== test/exposure_trig_source.sv ====
// Model of the external trigger source on the trigger pin
`timescale 1ns/100ps
module exposure_trig_source (
  input  wire logic mclk,
  output logic      trigPin
);
  logic activeLow = 1'b0;  // Selected polarity
  initial trigPin = 1'b0;
  // One active pulse, widened to the pin minima
  task automatic pulse(input int n);
    int w;
    w = activeLow ? ((n < 2) ? 2 : n) : ((n < 6) ? 6 : n);
    @(posedge mclk);
    trigPin <= ~activeLow;
    repeat (w) @(posedge mclk);
    trigPin <= activeLow;
  endtask
  // Idle level follows the polarity
  task automatic setPolarity(input logic low);
    activeLow = low;
    @(posedge mclk);
    trigPin <= low;
  endtask
endmodule

// ==== test/line_scan_exposure_control_sva.sv ====
// Port checker of the line scan exposure controller
`timescale 1ns/100ps
module line_scan_exposure_control_sva #(
  parameter bit COLOUR = 1'b1
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [3:0]  addr,
  input wire logic [31:0] wrData,
  input wire logic        wrEn,
  input wire logic        rdEn,
  input wire logic [31:0] rdData,
  input wire logic        trigInternal,
  input wire logic        exposureInProgress,
  input wire logic [2:0]  channelExposure
);
  localparam int TLO = COLOUR ? 25 : 9;   // Tail window start
  localparam int THI = COLOUR ? 29 : 13;  // Tail window end
  logic [9:0] ctrl;   // Shadow of the control word
  logic [5:0] since;  // Cycles since a trigger or a write
  wire logic  intEn = ctrl[6] && (ctrl[9:7] == 3'h0);
  wire logic  indiv = ctrl[2] && (ctrl[1:0] == 2'h1);
  // --------------------
  // Helper logic
  // --------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= 10'h000;
    end else if (wrEn && addr == exposure_ctrl_pkg::REG_CTRL) begin
      ctrl <= wrData[9:0];
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      since <= 6'h3f;
    end else if (trigInternal || wrEn) begin
      since <= 6'h00;
    end else if (since != 6'h3f) begin
      since <= since + 6'h01;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_rd_idle;
    !$past(rdEn) |-> rdData == 32'h0;
  endproperty
  property p_chan_in_exp;
    (|channelExposure) |-> exposureInProgress;
  endproperty
  property p_end_together;
    (|($past(channelExposure) & ~channelExposure)) |-> channelExposure == 3'h0;
  endproperty
  property p_common;
    !indiv |-> (channelExposure == 3'h0 || channelExposure == 3'h7);
  endproperty
  property p_timed_start;
    intEn && ctrl[1:0] == 2'h1 && $rose(trigInternal) && !exposureInProgress
      |-> ##[2:6] exposureInProgress;
  endproperty
  property p_off_start;
    intEn && ctrl[1:0] == 2'h0 && $rose(trigInternal) && !exposureInProgress
      |-> ##[20:24] exposureInProgress;
  endproperty
  property p_pulse_start;
    intEn && ctrl[1:0] == 2'h2 && $rose(trigInternal) && !exposureInProgress
      |-> ##[10:14] exposureInProgress;
  endproperty
  property p_tail;
    intEn && ctrl[1:0] == 2'h2 && $fell(trigInternal) && exposureInProgress
      |-> exposureInProgress[*8] ##[TLO:THI] !exposureInProgress;
  endproperty
  property p_no_stray;
    intEn && $rose(exposureInProgress) |-> since < 6'd40;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray rdData");
  a_chan_in_exp: assert property (p_chan_in_exp) else $error("stray channel");
  a_end_together: assert property (p_end_together) else $error("channels end apart");
  a_common: assert property (p_common) else $error("channels differ");
  a_timed_start: assert property (p_timed_start) else $error("timed start");
  a_off_start: assert property (p_off_start) else $error("off start");
  a_pulse_start: assert property (p_pulse_start) else $error("pulse start");
  a_tail: assert property (p_tail) else $error("bad tail");
  a_no_stray: assert property (p_no_stray) else $error("stray start");
  c_exp: cover property ($rose(exposureInProgress));
  c_stagger: cover property (indiv && channelExposure == 3'h2);
  c_tail: cover property (ctrl[1:0] == 2'h2 && $fell(exposureInProgress));
endmodule
bind line_scan_exposure_control line_scan_exposure_control_sva #(.COLOUR(COLOUR)) chk_u (
  .mclk(mclk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
  .rdData(rdData), .trigInternal(trigInternal),
  .exposureInProgress(exposureInProgress), .channelExposure(channelExposure));

// ==== test/line_scan_exposure_control_tb_top.sv ====
// Self-checking bench of the line scan exposure controller
`timescale 1ns/100ps
module line_scan_exposure_control_tb_top;
  logic        mclk, rst_n, wrEn, rdEn, trigInternal, trigPin, exposureInProgress;
  logic [3:0]  addr;
  logic [31:0] wrData, rdData, v;
  logic [2:0]  channelExposure;
  int          numErrors, totalChecks, d, l, l2;
  line_scan_exposure_control #(.COLOUR(1'b1)) dut_u (.mclk(mclk), .rst_n(rst_n),
    .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .trigInternal(trigInternal), .trigPin(trigPin),
    .exposureInProgress(exposureInProgress), .channelExposure(channelExposure));
  exposure_trig_source pin_u (.mclk(mclk), .trigPin(trigPin));
  // --------------------
  // Shared tasks
  // --------------------
  task automatic check(input string what, input logic [31:0] seen, exp);
    totalChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic inRange(input string what, input int x, lo, hi);
    check(what, {31'h0, x >= lo && x <= hi}, 32'h1);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] dt);
    addr <= a;
    wrData <= dt;
    wrEn <= 1'b1;
    @(posedge mclk);
    wrEn <= 1'b0;
    @(posedge mclk);
  endtask
  // Read data stand one cycle; sample mid-cycle
  task automatic rd(input logic [3:0] a);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge mclk);
    rdEn <= 1'b0;
    @(negedge mclk);
    v = rdData;
    @(posedge mclk);
  endtask
  task automatic waitIdle();
    int n = 0;
    while (exposureInProgress !== 1'b0 && n < 1200) begin
      @(posedge mclk);
      n++;
    end
  endtask
  // Bounded wait for a start, then count the high cycles
  task automatic measure();
    d = 0;
    l = 0;
    while (exposureInProgress !== 1'b1 && d < 200) begin
      @(posedge mclk);
      d++;
    end
    while (exposureInProgress === 1'b1 && l < 2000) begin
      @(posedge mclk);
      l++;
    end
  endtask
  task automatic fire(input logic pin, input int w);
    waitIdle();
    fork
      if (pin) pin_u.pulse(w);
      else begin
        trigInternal <= 1'b1;
        repeat (w) @(posedge mclk);
        trigInternal <= 1'b0;
      end
      measure();
    join
  endtask
  // --------------------
  // Scenarios
  // --------------------
  task automatic testLimits();
    rd(4'h0); check("ctrl", v, 32'h0);
    rd(4'h4); check("duration", v, 32'h3e8);
    rd(4'h2); check("unmapped", v, 32'h0);
    wr(4'h8, 32'h1f4);
    rd(4'h8); check("period", v, 32'h2710);
    rd(4'hc); check("refused", v[4], 1'b1);
    wr(4'h4, 32'h5);
    rd(4'h4); check("dur min", v, 32'hb);
    wr(4'h4, 32'h64);
    wr(4'h8, 32'hc8);
    rd(4'hc); check("accepted", v[4], 1'b0);
    wr(4'h0, 32'h20);
    wr(4'h4, 32'h96);
    wr(4'h8, 32'h64);
    rd(4'h4); check("dur clamp", v, 32'h64);
    wr(4'h8, 32'hc8);
    wr(4'h0, 32'h0);
    waitIdle();
    measure();
    check("free span", l, 32'd19);
  endtask
  task automatic testTimed();
    wr(4'h0, 32'h41);
    fire(1'b0, 2);
    inRange("timed delay", d, 3, 6);
    check("timed span", l, 32'd42);
    wr(4'h0, 32'h40);
    fire(1'b0, 2);
    inRange("off delay", d, 21, 25);
    check("off span", l, 32'd19);
  endtask
  // Width difference passes straight through
  task automatic testPulse(input logic pin);
    fire(pin, 50);
    l2 = l;
    fire(pin, 80);
    check("pulse width", l - l2, 32'd30);
  endtask
  task automatic testIndividual();
    int c[3] = '{0, 0, 0};
    wr(4'h0, 32'h45);
    wr(4'h4, 32'h64);
    wr(4'h0, 32'h4d);
    wr(4'h4, 32'hc8);
    wr(4'h0, 32'h55);
    wr(4'h4, 32'h32);
    wr(4'h0, 32'h4d);
    rd(4'h4); check("green dur", v, 32'hc8);
    waitIdle();
    trigInternal <= 1'b1;
    repeat (90) begin
      @(posedge mclk);
      trigInternal <= 1'b0;
      for (int i = 0; i < 3; i++) c[i] += (channelExposure[i] === 1'b1);
    end
    check("green minus red", c[1] - c[0], 32'd10);
    check("red minus blue", c[0] - c[2], 32'd5);
    wr(4'h0, 32'h46);
    rd(4'h0); check("share forced", v[2], 1'b0);
  endtask
  // --------------------
  // Clock, reset and verdict
  // --------------------
  task automatic reportAndStop();
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (30000) @(posedge mclk);
    numErrors++;
    reportAndStop();
  end
  initial begin
    {rst_n, wrEn, rdEn, trigInternal, addr, wrData, numErrors, totalChecks} = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    testLimits();
    testTimed();
    wr(4'h0, 32'h42);
    testPulse(1'b0);
    wr(4'h0, 32'hc2);
    testPulse(1'b1);
    pin_u.setPolarity(1'b1);
    // Let the idle rise sync in before the source flips
    repeat (8) @(posedge mclk);
    wr(4'h0, 32'h140);
    fire(1'b1, 2);
    inRange("ttl low delay", d, 27, 33);
    testIndividual();
    reportAndStop();
  end
endmodule
